// ---- src/toner_supply_pkg.sv ----
// constants and types for the toner supply controller
package toner_supply_pkg;
	// sensor sample width, millivolt scale
	localparam int unsigned SENSE_W         = 12;
	// density window limits in millivolts
	localparam logic [11:0] WIN_LO_MV       = 12'h924; // 2340
	localparam logic [11:0] WIN_HI_MV       = 12'h99C; // 2460
	localparam logic [11:0] WIN_MID_MV      = 12'h95F; // 2399
	// largest sensor change not yet counted as movement, millivolts
	localparam logic [11:0] CHANGE_MV       = 12'h00A;
	// clock and timing
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned EMPTY_WAIT_MS   = 2000;
	localparam int unsigned EMPTY_WAIT_CYC  = (CLK_HZ / 1000) * EMPTY_WAIT_MS;
	localparam int unsigned TIMER_W         = 32;
	// reset values
	localparam logic [11:0] OFFSET_RST      = 12'h000;
	localparam logic        EMPTY_RST       = 1'b0;

	// two-bit motor command, hi line first
	typedef enum logic [1:0] {
		MOTOR_IDLE   = 2'b00,
		MOTOR_ROTATE = 2'b10,
		MOTOR_BRAKE  = 2'b11
	} motor_cmd_e;

	// controller states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADJUST = 3'b001,
		ST_FEED   = 3'b010,
		ST_BRAKE  = 3'b011,
		ST_EMPTY  = 3'b100
	} state_e;
endpackage : toner_supply_pkg

// ---- src/pin_sync.sv ----
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/10ps
module pin_sync
	#(parameter int unsigned WIDTH = 1)
	(
	input  wire logic             clk_sys_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
	);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			meta_reg <= '0;
			sync_o   <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule : pin_sync

// ---- src/toner_supply_control.sv ----
// toner supply controller: motor command, density loop, empty detect
`timescale 1ns/10ps
module toner_supply_control
	import toner_supply_pkg::*;
	#(parameter int unsigned EMPTY_WAIT = EMPTY_WAIT_CYC)
	(
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	input  wire logic [11:0] density_sensor_voltage_i,
	input  wire logic        cart_present_n_i,
	input  wire logic        adjust_start_i,
	input  wire logic        print_active_i,
	output logic             motor_cmd_hi_line_o,
	output logic             motor_cmd_lo_line_o,
	output logic             toner_empty_o,
	output logic             cart_present_o,
	output logic             adjust_busy_o,
	output logic [11:0]      sensor_offset_o
	);

	logic [12:0]        pins_sync;
	logic [11:0]        volt;
	logic               cart_ok;
	logic [11:0]        adj_volt;
	logic [12:0]        adj_plus;
	logic [12:0]        ref_plus;
	logic [11:0]        ref_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic               timer_done;
	logic               moved;
	logic               low_density;
	logic               in_window;
	state_e             state_reg;
	state_e             state_next;
	motor_cmd_e         cmd;

	// the sensor word crosses as a whole; it moves slowly, so a torn
	// sample only shifts one reading by a step and is retaken next cycle
	// sensor and cartridge pins pass two flops; adjust_start_i and print_active_i are used directly
	pin_sync #(.WIDTH(13)) u_sync (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.async_i   ({~cart_present_n_i, density_sensor_voltage_i}),
		.sync_o    (pins_sync)
	);

	assign volt    = pins_sync[11:0];
	assign cart_ok = pins_sync[12];

	// sensor value corrected by the adjustment offset
	assign adj_volt    = volt - sensor_offset_o;
	assign low_density = adj_volt > WIN_HI_MV;
	assign in_window   = (adj_volt >= WIN_LO_MV) && (adj_volt <= WIN_HI_MV);

	// movement test in 13 bits so the threshold never wraps
	assign adj_plus = {1'b0, adj_volt} + 13'(CHANGE_MV);
	assign ref_plus = {1'b0, ref_reg} + 13'(CHANGE_MV);
	assign moved    = ({1'b0, adj_volt} > ref_plus) || ({1'b0, ref_reg} > adj_plus);

	// no-change limit reached while the motor turns
	assign timer_done = timer_reg >= TIMER_W'(EMPTY_WAIT);

	// next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (adjust_start_i)
					state_next = ST_ADJUST;
				else if (cart_ok && print_active_i && low_density)
					state_next = ST_FEED;
			end

			// adjustment lasts one cycle
			ST_ADJUST:
			begin
				state_next = ST_IDLE;
			end

			// feeding: brake on cartridge loss or recovered density, enter empty on no movement
			ST_FEED:
			begin
				if (!cart_ok)
					state_next = ST_BRAKE;
				else if (!moved && timer_done)
					state_next = ST_EMPTY;
				else if (!low_density)
					state_next = ST_BRAKE;
			end

			// empty: motor keeps turning until density comes back or the cartridge is lost
			ST_EMPTY:
			begin
				if (!cart_ok)
					state_next = ST_BRAKE;
				else if (moved && in_window)
					state_next = ST_BRAKE;
			end

			// brake lasts one cycle, then idle
			ST_BRAKE:
			begin
				state_next = ST_IDLE;
			end

			// unused codes fall back to idle
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// no-change timer: counts feeding cycles without sensor movement
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			timer_reg <= '0;
		else if (state_reg != state_next || moved)
			timer_reg <= '0; // restart on movement or state change
		else if (state_reg == ST_FEED)
			timer_reg <= timer_reg + 1'b1;
	end

	// reference sample: reading at the last movement or state change
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			ref_reg <= 12'h000;
		else if (state_reg != state_next || moved)
			ref_reg <= adj_volt;
	end

	// adjustment busy flag, high for the one adjust cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			adjust_busy_o <= 1'b0;
		else
			adjust_busy_o <= (state_next == ST_ADJUST);
	end

	// adjustment offset: current reading lands on window centre
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			sensor_offset_o <= OFFSET_RST;
		else if (state_reg == ST_ADJUST)
			sensor_offset_o <= volt - WIN_MID_MV;
	end

	// motor command decode
	always_comb
	begin
		case (state_next)
			ST_IDLE:   cmd = MOTOR_IDLE;
			ST_ADJUST: cmd = MOTOR_IDLE;
			ST_FEED:   cmd = MOTOR_ROTATE;
			ST_EMPTY:  cmd = MOTOR_ROTATE;
			ST_BRAKE:  cmd = MOTOR_BRAKE;
			default:   cmd = MOTOR_IDLE;
		endcase
	end

	// bridge command lines, registered decode of the next state
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			motor_cmd_hi_line_o <= 1'b0;
			motor_cmd_lo_line_o <= 1'b0;
		end
		else
		begin
			motor_cmd_hi_line_o <= cmd[1];
			motor_cmd_lo_line_o <= cmd[0];
		end
	end

	// cartridge presence, one flop after the synchroniser
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			cart_present_o <= 1'b0;
		else
			cart_present_o <= cart_ok;
	end

	// toner-empty flag to the display: set on entry, cleared on exit
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			toner_empty_o <= EMPTY_RST;
		else if (state_next == ST_EMPTY)
			toner_empty_o <= 1'b1;
		else if (state_reg == ST_EMPTY)
			toner_empty_o <= 1'b0;
	end
endmodule : toner_supply_control

// ---- sim/tsc_asserts.sv ----
// toner supply controller assertions
`timescale 1ns/10ps
module tsc_asserts
	(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic cart_present_n_i,
	input wire logic print_active_i,
	input wire logic motor_cmd_hi_line_o,
	input wire logic motor_cmd_lo_line_o,
	input wire logic toner_empty_o,
	input wire logic cart_present_o,
	input wire logic adjust_busy_o
	);
	wire h = motor_cmd_hi_line_o;
	wire l = motor_cmd_lo_line_o;
	wire e = toner_empty_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// motor codes and their order
	chk_code_legal: assert property (h || !l) else $error("bad code");
	chk_brake_entry: assert property ($rose(l) |-> h && $past(h)) else $error("brake");
	chk_brake_once: assert property (h && l |=> !h && !l) else $error("idle");
	chk_feed_cause: assert property ($rose(h) |-> $past(print_active_i)) else $error("feed");
	// empty flag, cartridge, adjust
	chk_empty_set: assert property ($rose(e) |-> h && !l && $past(h)) else $error("set");
	chk_empty_clear: assert property (!$past(srst_i) && $fell(e) |-> h && l)
		else $error("clear");
	chk_cart_follow: assert property ($changed(cart_present_n_i) |-> ##3
		cart_present_o != cart_present_n_i) else $error("cart");
	chk_busy_pulse: assert property (adjust_busy_o |=> !adjust_busy_o) else $error("busy");
	cover property (h && l);
	cover property ($rose(e));
	cover property (adjust_busy_o);
endmodule : tsc_asserts
bind toner_supply_control tsc_asserts u_chk (.*);

// ---- sim/toner_plant.sv ----
// bridge driver and density sensor model
`timescale 1ns/10ps
module toner_plant
	(
	input  wire logic        clk_sys_i,
	input  wire logic        hi_i,
	input  wire logic        lo_i,
	input  wire logic        has_toner_i,
	input  wire logic        load_i,
	input  wire logic [11:0] load_val_i,
	output logic      [11:0] volt_o,
	output wire logic [1:0]  coil_o
	);
	// bridge outputs, floating when both inputs low
	assign coil_o = (hi_i | lo_i) ? {hi_i & ~lo_i, lo_i & ~hi_i} : 2'hZ;
	// preset by the bench; fed toner raises density, voltage falls
	always @(posedge clk_sys_i)
	begin
		if (load_i)
			volt_o <= load_val_i;
		else if (hi_i && !lo_i && has_toner_i)
			volt_o <= volt_o - 12'h00F;
	end
endmodule : toner_plant

// ---- sim/tb.sv ----
// toner supply controller bench
`timescale 1ns/10ps
module tb;
	import toner_supply_pkg::*;
	localparam logic [11:0] START_MV = 12'h99F;
	logic clk_sys_i, srst_i, cart_n, pa, adj, ton, ld, h, l, e, cart, busy;
	logic [11:0] v, ld_val, offs;
	wire  [1:0]  coil;
	int mismatches, checks_done, i;
	wire [4:0] c = {busy, !e, e, l, h};
	toner_supply_control #(.EMPTY_WAIT(20)) dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.density_sensor_voltage_i(v), .cart_present_n_i(cart_n), .adjust_start_i(adj),
		.print_active_i(pa), .motor_cmd_hi_line_o(h), .motor_cmd_lo_line_o(l),
		.toner_empty_o(e), .cart_present_o(cart), .adjust_busy_o(busy), .sensor_offset_o(offs));
	toner_plant plant (.clk_sys_i(clk_sys_i), .hi_i(h), .lo_i(l), .has_toner_i(ton),
		.load_i(ld), .load_val_i(ld_val), .volt_o(v), .coil_o(coil));
	// free running clock
	initial forever #20 clk_sys_i = ~clk_sys_i;
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task chk(input string n, input logic [11:0] x, g);
		checks_done++;
		mismatches += (g !== x);
		if (g !== x) $display("ERROR %s expected %h seen %h", n, x, g);
	endtask : chk
	// bounded wait on one output
	task wt(input int s);
		for (i = 0; i < 60 && c[s] !== 1'h1; i++) @(negedge clk_sys_i);
		mismatches += (i == 60);
		if (i == 60) conclude();
	endtask : wt
	// preset the sensor model for one clock
	task load_volt(input logic [11:0] val);
		ld_val = val;
		ld = 1'h1;
		@(negedge clk_sys_i);
		ld = 1'h0;
	endtask : load_volt
	task t_adjust;
		adj = 1'h1;
		@(negedge clk_sys_i);
		adj = 1'h0;
		wt(4);
		@(negedge clk_sys_i);
		chk("busy", 1'h0, busy);
		repeat (2) @(negedge clk_sys_i);
		chk("offset", START_MV - WIN_MID_MV, offs);
	endtask : t_adjust
	task t_cart;
		repeat (4) @(negedge clk_sys_i);
		chk("cart", 1'h0, cart);
		cart_n = 1'h0;
		repeat (4) @(negedge clk_sys_i);
		chk("cart", 1'h1, cart);
	endtask : t_cart
	task t_feed;
		ton = 1'h1;
		load_volt(12'h9E0);
		pa = 1'h1;
		wt(0);
		chk("rotate", 2'h2, {h, l});
		chk("coil", 2'h2, coil);
		wt(1);
		chk("brake", 2'h3, {h, l});
		@(negedge clk_sys_i);
		chk("idle", 2'h0, {h, l});
		pa = 1'h0;
	endtask : t_feed
	task t_empty;
		ton = 1'h0;
		load_volt(12'h9E0);
		pa = 1'h1;
		wt(2);
		chk("empty", 1'h1, e);
		chk("rotate", 2'h2, {h, l});
		ton = 1'h1;
		wt(3);
		chk("brake", 2'h3, {h, l});
		chk("empty", 1'h0, e);
		pa = 1'h0;
	endtask : t_empty
	// reset, then scenarios
	initial
	begin
		clk_sys_i = 1'h0;
		srst_i = 1'h1;
		cart_n = 1'h1;
		{pa, adj, ton} = 3'h0;
		mismatches = 0;
		checks_done = 0;
		ld = 1'h1;
		ld_val = START_MV;
		repeat (10) @(negedge clk_sys_i);
		srst_i = 1'h0;
		ld = 1'h0;
		// let the sensor reading pass the synchroniser first
		repeat (3) @(negedge clk_sys_i);
		t_adjust();
		t_cart();
		t_feed();
		t_empty();
		conclude();
	end
endmodule : tb
